/* fsd_core.sv */
// Flow and system control execution core: program counter, stack, page/bank and sleep
// Operation
// (RULE_01) Call pushes counter plus one, loads bits 7:0 from the operand, clears bit 8, takes page bits, 3 cycles.
// (RULE_02) Jump loads bits 8:0 from its operand and 11:9 from the page bits in 3 cycles, flags untouched.
// (RULE_03) Plain return reloads the counter from the stack top in 3 cycles with no flag change.
// (RULE_04) Page return also copies stacked bits 11:9 into the status page bits.
// (RULE_05) Interrupt return restores accumulator, status, file select, mode and counter from shadows except expiry and power-down.
// (RULE_06) Interrupt return with timer adjust also adds the accumulator to the real-time counter.
// (RULE_07) Literal return loads its immediate into the accumulator and pops the counter in 3 cycles.
// (RULE_08) Bank select writes its 3-bit field into file select bits 6:4 in one cycle.
// (RULE_09) Program word fetch reads the word at mode:accumulator and returns it into that pair in 4 cycles.
// (RULE_10) Page select writes its 3-bit field into status bits 7:5 in one cycle.
// (RULE_11) Sleep clears the watchdog, sets expiry, clears power-down, clears the prescaler if assigned, stops the oscillator.
// (RULE_12) The all-zero opcode is a one-cycle no-op.
// (RULE_13) Status holds carry at bit 0 and zero at bit 2, so a bit clear there clears that flag.
// (RULE_14) A bit-test skip costs one cycle when false and two when true.
// (RULE_15) Writing or adding the accumulator to the counter register is an indirect jump of 3 cycles.
// (RULE_16) Undefined opcodes execute as one-cycle no-ops.
`timescale 1ns/1ps
`default_nettype none
module fsd_core
   import fsd_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        instr_valid_in,
   input  wire logic [11:0] instr_in,
   input  wire logic        skip_test_in,
   input  wire logic        skip_cond_in,
   input  wire logic        pc_write_in,
   input  wire logic        pc_add_in,
   input  wire logic        bit_clear_in,
   input  wire logic [7:0]  bit_clear_addr_in,
   input  wire logic [2:0]  bit_clear_pos_in,
   input  wire logic [7:0]  shadow_w_in,
   input  wire logic [7:0]  shadow_status_in,
   input  wire logic [7:0]  shadow_fsr_in,
   input  wire logic [3:0]  shadow_mode_in,
   input  wire logic [11:0] shadow_pc_in,
   input  wire logic [11:0] pmem_data_in,
   input  wire logic        prescaler_to_wdt_in,
   input  wire logic        wake_in,
   input  wire logic        realtime_counter_tick_in,
   output logic             ready_out,
   output logic [11:0]      pc_out,
   output logic [7:0]       w_out,
   output logic [7:0]       status_out,
   output logic [7:0]       fsr_out,
   output logic [3:0]       mode_out,
   output logic [7:0]       realtime_counter_out,
   output logic [11:0]      pmem_addr_out,
   output logic             pmem_rd_out,
   output logic             wdt_clear_out,
   output logic             prescaler_clear_out,
   output logic             osc_stop_out
);
   localparam int SPW = $clog2(STACK_DEPTH);

   // Elaboration guard: the stack pointer wraps cleanly only for a power-of-two depth
   if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_depth_check
      $error("STACK_DEPTH must be a power of two of at least 2");
   end

   fsd_dec_if dec_bus ();
   assign dec_bus.opcode = instr_in;

   fsd_decode u_decode (
      .bus (dec_bus)
   );

   fsd_state_type   state_ff, nxt_state;
   logic [2:0]      cnt_ff, nxt_cnt;
   logic [11:0]     pc_ff, nxt_pc;
   logic [7:0]      w_ff, nxt_w;
   logic [7:0]      status_ff, nxt_status;
   logic [7:0]      fsr_ff, nxt_fsr;
   logic [3:0]      mode_ff, nxt_mode;
   logic [7:0]      realtime_counter_ff, nxt_realtime_counter;
   logic [11:0]     paddr_ff, nxt_paddr;
   logic            prd_ff, nxt_prd;
   logic            wdtc_ff, nxt_wdtc;
   logic            presc_ff, nxt_presc;
   logic            osc_ff, nxt_osc;
   logic            ready_ff;
   logic [SPW-1:0]  sp_ff, nxt_sp;
   logic [11:0]     stack_ff [STACK_DEPTH];
   logic            push;
   logic [11:0]     top;

   // Counter plus a step of one or two, wrapping inside the 12-bit space
   function automatic logic [11:0] inc_pc(input logic [11:0] pc, input logic [11:0] step);
      inc_pc = pc + step;
   endfunction

   assign top = stack_ff[sp_ff - SPW'(1)];

   // Next-state logic for every architectural register
   always_comb begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_pc     = pc_ff;
      nxt_w      = w_ff;
      nxt_status = status_ff;
      nxt_fsr    = fsr_ff;
      nxt_mode   = mode_ff;
      nxt_realtime_counter   = realtime_counter_tick_in ? realtime_counter_ff + 8'h01 : realtime_counter_ff;
      nxt_paddr  = paddr_ff;
      nxt_prd    = 1'b0;
      nxt_wdtc   = 1'b0;
      nxt_presc  = 1'b0;
      nxt_osc    = osc_ff;
      nxt_sp     = sp_ff;
      push       = 1'b0;
      case (state_ff)
         FSD_RUN: begin
            // Side requests win over a fetched opcode; only one is served per cycle
            if (pc_write_in || pc_add_in) begin
               nxt_pc[7:0] = pc_write_in ? w_ff : pc_ff[7:0] + w_ff; // [RULE_15]
               nxt_pc[8]   = 1'b0;
               nxt_pc[11:9] = status_ff[BIT_PAGE_LO +: 3];
               nxt_cnt     = CYC_BRANCH - 3'h1; // [RULE_15]
               nxt_state   = FSD_STALL;
            end else if (bit_clear_in) begin
               // Only status lives here; carry and zero sit at 0 and 2
               if (bit_clear_addr_in == ADDR_STATUS)
                  nxt_status[bit_clear_pos_in] = 1'b0; // [RULE_13]
               nxt_pc = inc_pc(pc_ff, 12'h001);
            end else if (skip_test_in) begin
               if (skip_cond_in) begin
                  nxt_pc    = inc_pc(pc_ff, 12'h002); // [RULE_14]
                  nxt_cnt   = CYC_SKIP - 3'h1;
                  nxt_state = FSD_STALL;
               end else begin
                  nxt_pc = inc_pc(pc_ff, 12'h001); // [RULE_14]
               end
            end else if (instr_valid_in) begin
               nxt_pc  = inc_pc(pc_ff, 12'h001);
               nxt_cnt = dec_bus.cycles - 3'h1;
               if (dec_bus.cycles != CYC_ONE)
                  nxt_state = FSD_STALL;
               case (dec_bus.op)
                  FSD_CALL: begin
                     push   = 1'b1; // [RULE_01]
                     nxt_sp = sp_ff + SPW'(1);
                     nxt_pc = {status_ff[BIT_PAGE_LO +: 3], 1'b0, instr_in[7:0]}; // [RULE_01]
                  end
                  FSD_JUMP: nxt_pc = {status_ff[BIT_PAGE_LO +: 3], instr_in[8:0]}; // [RULE_02]
                  FSD_RET: begin
                     nxt_pc = top; // [RULE_03]
                     nxt_sp = sp_ff - SPW'(1);
                  end
                  FSD_RET_PAGE: begin
                     nxt_pc = top;
                     nxt_sp = sp_ff - SPW'(1);
                     nxt_status[BIT_PAGE_LO +: 3] = top[11:9]; // [RULE_04]
                  end
                  FSD_RET_ISR, FSD_RET_ISRT: begin
                     nxt_w      = shadow_w_in; // [RULE_05]
                     nxt_fsr    = shadow_fsr_in;
                     nxt_mode   = shadow_mode_in;
                     nxt_pc     = shadow_pc_in;
                     nxt_status = shadow_status_in;
                     nxt_status[BIT_EXPIRY] = status_ff[BIT_EXPIRY]; // [RULE_05]
                     nxt_status[BIT_PDOWN]  = status_ff[BIT_PDOWN];
                     // Restored accumulator is the one added, as software sees it afterwards
                     if (dec_bus.op == FSD_RET_ISRT)
                        nxt_realtime_counter = nxt_realtime_counter + shadow_w_in; // [RULE_06]
                  end
                  FSD_RETLIT: begin
                     nxt_w  = instr_in[7:0]; // [RULE_07]
                     nxt_pc = top;
                     nxt_sp = sp_ff - SPW'(1);
                  end
                  FSD_BANK: nxt_fsr[BIT_BANK_LO +: 3] = instr_in[2:0]; // [RULE_08]
                  FSD_PAGE: nxt_status[BIT_PAGE_LO +: 3] = instr_in[2:0]; // [RULE_10]
                  FSD_PWFETCH: begin
                     nxt_paddr = {mode_ff, w_ff}; // [RULE_09]
                     nxt_prd   = 1'b1;
                     nxt_state = FSD_FETCH;
                  end
                  FSD_SLEEP: begin
                     nxt_wdtc   = 1'b1; // [RULE_11]
                     nxt_presc  = prescaler_to_wdt_in;
                     nxt_status[BIT_EXPIRY] = 1'b1;
                     nxt_status[BIT_PDOWN]  = 1'b0;
                     nxt_osc    = 1'b1;
                     nxt_state  = FSD_SLEEPING;
                  end
                  default: ; // Only the counter advances [RULE_12]
               endcase
            end
         end
         FSD_STALL: begin
            nxt_cnt = cnt_ff - 3'h1;
            if (cnt_ff == 3'h1)
               nxt_state = FSD_RUN;
         end
         FSD_FETCH: begin
            // Memory answers one cycle after the read strobe; captured in the last cycle
            nxt_cnt = cnt_ff - 3'h1;
            if (cnt_ff == 3'h1) begin
               nxt_mode  = pmem_data_in[11:8]; // [RULE_09]
               nxt_w     = pmem_data_in[7:0];
               nxt_state = FSD_RUN;
            end
         end
         FSD_SLEEPING: begin
            // The core holds all state but the real-time counter until a wake-up releases the oscillator
            if (wake_in) begin
               nxt_osc   = 1'b0;
               nxt_state = FSD_RUN;
            end
         end
         default: nxt_state = FSD_RUN;
      endcase
   end

   // Registers; the stack array has no reset since stale entries are never meaningful
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_ff  <= FSD_RUN;
         cnt_ff    <= 3'h0;
         pc_ff     <= RST_PC;
         w_ff      <= RST_BYTE;
         status_ff <= RST_STATUS;
         fsr_ff    <= RST_BYTE;
         mode_ff   <= RST_MODE;
         realtime_counter_ff   <= RST_BYTE;
         paddr_ff  <= 12'h000;
         prd_ff    <= 1'b0;
         wdtc_ff   <= 1'b0;
         presc_ff  <= 1'b0;
         osc_ff    <= 1'b0;
         ready_ff  <= 1'b1;
         sp_ff     <= '0;
      end else begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         pc_ff     <= nxt_pc;
         w_ff      <= nxt_w;
         status_ff <= nxt_status;
         fsr_ff    <= nxt_fsr;
         mode_ff   <= nxt_mode;
         realtime_counter_ff   <= nxt_realtime_counter;
         paddr_ff  <= nxt_paddr;
         prd_ff    <= nxt_prd;
         wdtc_ff   <= nxt_wdtc;
         presc_ff  <= nxt_presc;
         osc_ff    <= nxt_osc;
         ready_ff  <= (nxt_state == FSD_RUN);
         sp_ff     <= nxt_sp;
      end
   end

   // Return address push; a full stack silently wraps over the oldest entry
   always_ff @(posedge clk_in) begin
      if (push)
         stack_ff[sp_ff] <= inc_pc(pc_ff, 12'h001); // [RULE_01]
   end

   assign ready_out           = ready_ff;
   assign pc_out              = pc_ff;
   assign w_out               = w_ff;
   assign status_out          = status_ff;
   assign fsr_out             = fsr_ff;
   assign mode_out            = mode_ff;
   assign realtime_counter_out            = realtime_counter_ff;
   assign pmem_addr_out       = paddr_ff;
   assign pmem_rd_out         = prd_ff;
   assign wdt_clear_out       = wdtc_ff;
   assign prescaler_clear_out = presc_ff;
   assign osc_stop_out        = osc_ff;
endmodule
`default_nettype wire

/* fsd_pkg.sv */
// Shared constants and types for the flow and system control decoder
package fsd_pkg;
   // Opcode patterns and masks (12-bit instruction words)
   localparam logic [11:0] OP_NOP       = 12'h000;
   localparam logic [11:0] OP_SLEEP     = 12'h003;
   localparam logic [11:0] OP_RET       = 12'h00c;
   localparam logic [11:0] OP_RET_PAGE  = 12'h00d;
   localparam logic [11:0] OP_RET_ISR   = 12'h00e;
   localparam logic [11:0] OP_RET_ISRT  = 12'h00f;
   localparam logic [11:0] OP_PWFETCH   = 12'h041;
   localparam logic [11:0] OP_PAGE      = 12'h010;
   localparam logic [11:0] OP_BANK      = 12'h018;
   localparam logic [11:0] MASK_SEL     = 12'hff8;
   localparam logic [11:0] OP_RETLIT    = 12'h800;
   localparam logic [11:0] OP_CALL      = 12'h900;
   localparam logic [11:0] MASK_LIT     = 12'hf00;
   localparam logic [11:0] OP_JUMP      = 12'ha00;
   localparam logic [11:0] MASK_JUMP    = 12'he00;
   // Cycle counts per instruction class
   localparam logic [2:0]  CYC_ONE      = 3'h1;
   localparam logic [2:0]  CYC_SKIP     = 3'h2;
   localparam logic [2:0]  CYC_BRANCH   = 3'h3;
   localparam logic [2:0]  CYC_FETCH    = 3'h4;
   // File addresses and status and file select bit positions
   localparam logic [7:0]  ADDR_PC      = 8'h02;
   localparam logic [7:0]  ADDR_STATUS  = 8'h03;
   localparam int          BIT_CARRY    = 0;
   localparam int          BIT_ZERO     = 2;
   localparam int          BIT_PDOWN    = 3;
   localparam int          BIT_EXPIRY   = 4;
   localparam int          BIT_PAGE_LO  = 5;
   localparam int          BIT_BANK_LO  = 4;
   // Values after reset
   localparam logic [11:0] RST_PC       = 12'hfff;
   localparam logic [7:0]  RST_STATUS   = 8'h18;
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [3:0]  RST_MODE     = 4'hf;

   typedef enum logic [3:0] {
      FSD_NOP, FSD_CALL, FSD_JUMP, FSD_RET, FSD_RET_PAGE, FSD_RET_ISR,
      FSD_RET_ISRT, FSD_RETLIT, FSD_BANK, FSD_PWFETCH, FSD_PAGE, FSD_SLEEP
   } fsd_op_type;

   typedef enum logic [1:0] {FSD_RUN, FSD_STALL, FSD_FETCH, FSD_SLEEPING} fsd_state_type;
endpackage

/* fsd_dec_if.sv */
// Decoder-to-core carrier for the opcode and its decoded class
`timescale 1ns/1ps
`default_nettype none
interface fsd_dec_if;
   import fsd_pkg::*;
   logic [11:0] opcode;
   fsd_op_type  op;
   logic [2:0]  cycles;
   modport dec  (input opcode, output op, output cycles);
   modport core (output opcode, input op, input cycles);
endinterface
`default_nettype wire

/* fsd_decode.sv */
// Combinational opcode classifier for flow and system control instructions
`timescale 1ns/1ps
`default_nettype none
module fsd_decode
   import fsd_pkg::*;
(
   fsd_dec_if.dec bus
);
   // Masked matches first, exact codes next; anything else falls to a no-op
   always_comb begin
      bus.op     = FSD_NOP;
      bus.cycles = CYC_ONE;
      if ((bus.opcode & MASK_LIT) == OP_CALL) begin
         bus.op     = FSD_CALL;
         bus.cycles = CYC_BRANCH;
      end else if ((bus.opcode & MASK_JUMP) == OP_JUMP) begin
         bus.op     = FSD_JUMP;
         bus.cycles = CYC_BRANCH;
      end else if ((bus.opcode & MASK_LIT) == OP_RETLIT) begin
         bus.op     = FSD_RETLIT;
         bus.cycles = CYC_BRANCH;
      end else if ((bus.opcode & MASK_SEL) == OP_BANK) begin
         bus.op = FSD_BANK;
      end else if ((bus.opcode & MASK_SEL) == OP_PAGE) begin
         bus.op = FSD_PAGE;
      end else begin
         case (bus.opcode)
            OP_RET: begin
               bus.op     = FSD_RET;
               bus.cycles = CYC_BRANCH;
            end
            OP_RET_PAGE: begin
               bus.op     = FSD_RET_PAGE;
               bus.cycles = CYC_BRANCH;
            end
            OP_RET_ISR: begin
               bus.op     = FSD_RET_ISR;
               bus.cycles = CYC_BRANCH;
            end
            OP_RET_ISRT: begin
               bus.op     = FSD_RET_ISRT;
               bus.cycles = CYC_BRANCH;
            end
            OP_PWFETCH: begin
               bus.op     = FSD_PWFETCH;
               bus.cycles = CYC_FETCH;
            end
            OP_SLEEP: bus.op = FSD_SLEEP;
            default:  bus.op = FSD_NOP; // Undefined codes run as one-cycle no-ops [RULE_16]
         endcase
      end
   end
endmodule
`default_nettype wire

/* fsd_core_chk.sv */
// Port-level assertions for the flow and system control core
`timescale 1ns/1ps
`default_nettype none
module fsd_core_chk
   import fsd_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic        instr_valid_in,
   input wire logic [11:0] instr_in,
   input wire logic        skip_test_in,
   input wire logic        skip_cond_in,
   input wire logic        pc_write_in,
   input wire logic        pc_add_in,
   input wire logic        bit_clear_in,
   input wire logic        ready_out,
   input wire logic [11:0] pc_out,
   input wire logic [7:0]  w_out,
   input wire logic [7:0]  status_out,
   input wire logic [7:0]  fsr_out,
   input wire logic [3:0]  mode_out,
   input wire logic [11:0] pmem_addr_out,
   input wire logic        pmem_rd_out,
   input wire logic        wdt_clear_out,
   input wire logic        osc_stop_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // An opcode is only taken when no side strobe outranks it
   wire logic side = pc_write_in | pc_add_in | bit_clear_in | skip_test_in;
   wire logic take = ready_out & instr_valid_in & ~side;
   wire logic sel  = ready_out & ~(pc_write_in | pc_add_in | bit_clear_in);
   property p_call; take && instr_in[11:8] == 4'h9 |=> pc_out == {$past(status_out[7:5]), 1'b0,
      $past(instr_in[7:0])} && !ready_out ##1 !ready_out ##1 ready_out; endproperty
   a_call: assert property (p_call) else $error("call target wrong");
   property p_jump; take && instr_in[11:9] == 3'h5 |=> pc_out == {$past(status_out[7:5]),
      $past(instr_in[8:0])} && $stable(status_out) ##2 ready_out; endproperty
   a_jump: assert property (p_jump) else $error("jump target wrong");
   property p_retlit; take && instr_in[11:8] == 4'h8 |=> w_out == $past(instr_in[7:0]); endproperty
   a_retlit: assert property (p_retlit) else $error("literal return value wrong");
   property p_bank; take && (instr_in & MASK_SEL) == OP_BANK |=> fsr_out[6:4] == $past(instr_in[2:0])
      && ready_out; endproperty
   a_bank: assert property (p_bank) else $error("bank select wrong");
   property p_page; take && (instr_in & MASK_SEL) == OP_PAGE |=> status_out[7:5] == $past(instr_in[2:0])
      && ready_out; endproperty
   a_page: assert property (p_page) else $error("page select wrong");
   property p_fetch; take && instr_in == OP_PWFETCH |=> pmem_rd_out && !ready_out && pmem_addr_out ==
      {$past(mode_out), $past(w_out)} ##3 ready_out; endproperty
   a_fetch: assert property (p_fetch) else $error("word fetch wrong");
   property p_sleep; take && instr_in == OP_SLEEP |=> wdt_clear_out && osc_stop_out && status_out[4]
      && !status_out[3] && !ready_out; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
   property p_skip; sel && skip_test_in |=> pc_out == $past(pc_out) + ($past(skip_cond_in) ? 12'h2 :
      12'h1) && ready_out == !$past(skip_cond_in); endproperty
   a_skip: assert property (p_skip) else $error("skip timing wrong");
   property p_pcw; ready_out && pc_write_in |=> pc_out == {$past(status_out[7:5]), 1'b0, $past(w_out)}
      && !ready_out ##2 ready_out; endproperty
   a_pcw: assert property (p_pcw) else $error("indirect jump wrong");
endmodule
bind fsd_core fsd_core_chk fsd_core_chk_inst (
   .clk_in(clk_in), .rstn_in(rstn_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
   .skip_test_in(skip_test_in), .skip_cond_in(skip_cond_in), .pc_write_in(pc_write_in),
   .pc_add_in(pc_add_in), .bit_clear_in(bit_clear_in), .ready_out(ready_out), .pc_out(pc_out),
   .w_out(w_out), .status_out(status_out), .fsr_out(fsr_out), .mode_out(mode_out),
   .pmem_addr_out(pmem_addr_out), .pmem_rd_out(pmem_rd_out), .wdt_clear_out(wdt_clear_out),
   .osc_stop_out(osc_stop_out));
`default_nettype wire

/* tb_fsd_core.sv */
// Self-checking bench with a reference model of the core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_fsd_core;
   import fsd_pkg::*;
   logic        clk_in = 0, rstn_in = 0, iv = 0, sk = 0, sc = 0, pw = 0, pa = 0, bc = 0, wk = 0, pt = 0;
   logic        rdy, prd, wdc, psc, osc;
   logic [11:0] instr = 0, spc = 0, pmd = 0, pc, pma, mpc, mpa = 0, stk[$];
   logic [7:0]  ba = 0, sw = 0, ss = 0, sf = 0, w, st, file_select_register, rt, mw, mst, mf, mrt;
   logic [3:0]  sm = 0, md, mm;
   logic [2:0]  bp = 0;
   logic [31:0] r = 32'h4ec73707;
   int          n_fail = 0, tests_run = 0, cyc = 0, n;
   fsd_core fsd_core_inst (.clk_in(clk_in), .rstn_in(rstn_in), .instr_valid_in(iv), .instr_in(instr),
      .skip_test_in(sk), .skip_cond_in(sc), .pc_write_in(pw), .pc_add_in(pa), .bit_clear_in(bc),
      .bit_clear_addr_in(ba), .bit_clear_pos_in(bp), .shadow_w_in(sw), .shadow_status_in(ss),
      .shadow_fsr_in(sf), .shadow_mode_in(sm), .shadow_pc_in(spc), .pmem_data_in(pmd),
      .prescaler_to_wdt_in(pt), .wake_in(wk), .realtime_counter_tick_in(1'b0), .ready_out(rdy), .pc_out(pc),
      .w_out(w), .status_out(st), .fsr_out(file_select_register), .mode_out(md), .realtime_counter_out(rt), .pmem_addr_out(pma),
      .pmem_rd_out(prd), .wdt_clear_out(wdc), .prescaler_clear_out(psc), .osc_stop_out(osc));
   // Free-running 100 MHz clock
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Model first (pre-op state), then drive one request and compare every result
   task automatic ex(input logic [3:0] s, input logic [11:0] op);
      int ec;
      ec = 1;
      if (s[3]) begin mpc = {mst[7:5], 1'b0, mw}; ec = 3; end
      else if (s[2]) begin mpc = {mst[7:5], 1'b0, mpc[7:0] + mw}; ec = 3; end
      else if (s[1]) begin if (ba == ADDR_STATUS) mst[bp] = 1'b0; mpc++; end
      else if (s[0]) begin mpc += sc ? 12'h2 : 12'h1; ec = sc ? 2 : 1; end
      else casez (op)
         12'b1001????????: begin stk.push_back(mpc + 12'h1); mpc = {mst[7:5], 1'b0, op[7:0]}; ec = 3; end
         12'b101?????????: begin mpc = {mst[7:5], op[8:0]}; ec = 3; end
         12'b1000????????: begin mw = op[7:0]; mpc = stk.pop_back(); ec = 3; end
         12'h00c: begin mpc = stk.pop_back(); ec = 3; end
         12'h00d: begin mpc = stk.pop_back(); mst[7:5] = mpc[11:9]; ec = 3; end
         12'h00e, 12'h00f: begin
            if (op[0]) mrt += sw;
            mw = sw; mst = {ss[7:5], mst[4:3], ss[2:0]}; mf = sf; mm = sm; mpc = spc; ec = 3;
         end
         12'b000000011???: begin mf[6:4] = op[2:0]; mpc++; end
         12'b000000010???: begin mst[7:5] = op[2:0]; mpc++; end
         12'h041: begin mpa = {mm, mw}; {mm, mw} = pmd; mpc++; ec = 4; end
         default: mpc++;
      endcase
      @(negedge clk_in); {pw, pa, bc, sk} = s; instr = op; iv = 1;
      @(negedge clk_in); {pw, pa, bc, sk} = 4'h0; iv = 0; n = 1;
      `CHK("rd_pulse", op == OP_PWFETCH && s == 4'h0, prd)
      while (rdy !== 1'b1 && n < 9) begin @(negedge clk_in); n++; end
      `CHK("cycles", ec, n)
      `CHK("pc", mpc, pc)
      `CHK("w", mw, w)
      `CHK("status", mst, st)
      `CHK("fsr", mf, file_select_register)
      `CHK("mode", mm, md)
      `CHK("realtime_counter", mrt, rt)
      `CHK("paddr", mpa, pma)
   endtask
   // Hang guard: a few hundred cycles are needed, the ceiling is far above
   always @(posedge clk_in) begin
      cyc++;
      if (cyc > 5000) begin n_fail++; test_done(); end
   end
   // Main sequence
   initial begin
      repeat (8) @(negedge clk_in);
      rstn_in = 1;
      mpc = RST_PC; mst = RST_STATUS; mw = RST_BYTE; mf = RST_BYTE; mrt = RST_BYTE; mm = RST_MODE;
      ex(4'h0, OP_NOP);
      for (int i = 0; i < 6; i++) begin
         r = lfsr(r); spc = r[11:0]; ss = r[19:12]; sw = r[27:20]; sf = r[31:24]; sm = r[3:0]; pmd = r[31:20];
         ex(4'h0, OP_RET_ISR | {11'h0, i[0]});
         ex(4'h0, OP_PAGE | r[2:0]);
         ex(4'h0, OP_BANK | r[5:3]);
         ex(4'h0, OP_CALL | r[13:6]);
         ex(4'h0, OP_RETLIT | r[21:14]);
         ex(4'h0, OP_CALL | r[9:2]);
         ex(4'h0, OP_PAGE | r[8:6]);
         ex(4'h0, OP_RET_PAGE);
         ex(4'h0, OP_CALL | r[7:0]);
         ex(4'h0, OP_RET);
         ex(4'h0, OP_JUMP | r[8:0]);
         ex(4'h0, OP_PWFETCH);
         ex(4'h8, r[11:0]);
         ex(4'h4, OP_CALL);
         ba = i[1] ? 8'h07 : ADDR_STATUS; bp = {i[0], 1'b0};
         ex(4'h2, OP_CALL);
         sc = i[0];
         ex(4'h1, OP_JUMP);
         ex(4'h0, 12'h0f0 | r[3:0]);
      end
      // Sleep with the prescaler given to the watchdog and not; a request while asleep must be ignored
      for (int k = 0; k < 2; k++) begin
         pt = k[0];
         wk = 0;
         mst[4:3] = 2'b10;
         mpc++;
         @(negedge clk_in); instr = OP_SLEEP; iv = 1;
         @(negedge clk_in); instr = OP_PAGE | {9'h0, ~mst[7:5]};
         `CHK("wdt_clear", 1'b1, wdc)
         `CHK("pre_clear", pt, psc)
         `CHK("osc_stop", 1'b1, osc)
         `CHK("status", mst, st)
         repeat (3) @(negedge clk_in);
         iv = 0;
         wk = 1;
         for (n = 0; n < 9 && rdy !== 1'b1; n++) @(negedge clk_in);
         `CHK("osc_run", 1'b0, osc)
         `CHK("pc_asleep", mpc, pc)
         `CHK("status_asleep", mst, st)
      end
      test_done();
   end
endmodule
`default_nettype wire
